// ### adsc_consts.vh
`ifndef ADSC_CONSTS_VH
`define ADSC_CONSTS_VH
`define ADSC_OFS_SEQ   8'h00
`define ADSC_OFS_CLK   8'h04
`define ADSC_OFS_DMA   8'h08
`define ADSC_OFS_CH123 8'h0c
`define ADSC_OFS_CH0   8'h10
`define ADSC_OFS_SCAN  8'h14
`define ADSC_OFS_PIN_DIGITAL_SELECT  8'h18
`define ADSC_OFS_RES   8'h1c
`define ADSC_SEQ_MASK  16'h003f
`define ADSC_CLK_MASK  16'h9fff
`define ADSC_DMA_MASK  16'h0007
`define ADSC_CH123_MASK 16'h0707
`define ADSC_CH0_MASK  16'h9f9f
`define ADSC_IN_MASK   16'h1fff
`define ADSC_BUFFER_FILL_STATUS_BIT  7
`define ADSC_BUFFER_FILL_MODE_BIT  1
`define ADSC_CONVERSIONS_PER_INTERRUPT_LSB  2
`define ADSC_RESET     16'h0000
`define ADSC_HALF_BASE 4'h8
`endif

// ### adsc_dma_sink.sv
`timescale 1ns/1ps
module adsc_dma_sink (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // stream in
  input  wire        stall,
  input  wire        dmaValid,
  input  wire [15:0] dmaData,
  input  wire [3:0]  dmaBufAddr,
  output reg         dmaReady,
  // tallies
  output reg  [15:0] rxCount,
  output reg  [15:0] rxSum,
  output reg  [3:0]  lastAddr
);
  reg slow_q;
  // slow taker, ready every other cycle
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      {dmaReady, slow_q, rxCount, rxSum, lastAddr} <= 38'h0;
    end else begin
      slow_q   <= ~slow_q;
      dmaReady <= !stall && slow_q;
      if (dmaValid && dmaReady) begin
        rxCount  <= rxCount + 16'h1;
        rxSum    <= rxSum + dmaData;
        lastAddr <= dmaBufAddr;
      end
    end
  end
endmodule

// ### adsc_fifo.v
`timescale 1ns/1ps
module adsc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             reset_n,
  // fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  wire            doWr;
  wire            doRd;
  assign inReady  = (count_q != DEPTH);
  assign outValid = (count_q != 0);
  assign outData  = mem[rdPtr_q];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;
  always @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
    if (!reset_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (doWr && !doRd) begin
        count_q <= count_q + 1'b1;
      end else if (doRd && !doWr) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ### adsc_props.sv
`timescale 1ns/1ps
module adsc_props #(
  parameter        SMALL_PKG = 0,
  parameter [12:0] PRESENT   = 13'h1fff
) (
  // clock and reset
  input wire        ref_clk,
  input wire        reset_n,
  // register bus
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire [1:0]  s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  // stream and front end
  input wire        convDone,
  input wire        dmaAdvance,
  input wire [7:0]  dmaWordsPerInput,
  input wire [4:0]  chZeroPosIdx,
  input wire        chZeroPosRef,
  input wire        chZeroNegRef,
  input wire [11:0] chOneThreeSel,
  input wire [12:0] scanUsesRef,
  input wire [12:0] pinDigital,
  input wire [12:0] muxToGround,
  input wire [8:0]  convClkDiv
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_adv; dmaAdvance |-> $past(convDone); endproperty
  property p_words; $onehot(dmaWordsPerInput); endproperty
  property p_neg;
    chOneThreeSel[11:10] != 2'b01 && chOneThreeSel[9:6] == (chOneThreeSel[11:10] == 2'b11 ?
      4'h9 : chOneThreeSel[11] ? 4'h6 : 4'h0);
  endproperty
  property p_pos; chOneThreeSel[3:0] == 4'h0 || chOneThreeSel[3:0] == 4'h3; endproperty
  property p_resv;
    SMALL_PKG != 0 && chZeroPosIdx >= 5'h06 && chZeroPosIdx <= 5'h08 |-> chZeroPosRef;
  endproperty
  property p_scan; (scanUsesRef & PRESENT) == 13'h0; endproperty
  property p_gnd; muxToGround == pinDigital; endproperty
  property p_ign; (pinDigital & ~PRESENT) == 13'h0; endproperty
  property p_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
  property p_err;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c |=> s_axi_rvalid && s_axi_rresp == 2'h2;
  endproperty
  property p_rst;
    $rose(reset_n) |-> convClkDiv == 9'h1 && dmaWordsPerInput == 8'h1 && chZeroNegRef;
  endproperty
  a_adv: assert property (p_adv) else $error("advance without conversion");
  a_words: assert property (p_words) else $error("words not a power of two");
  a_neg: assert property (p_neg) else $error("bad negative decode");
  a_pos: assert property (p_pos) else $error("bad positive decode");
  a_resv: assert property (p_resv) else $error("reserved input not flagged");
  a_scan: assert property (p_scan) else $error("present input uses reference");
  a_gnd: assert property (p_gnd) else $error("ground tie mismatch");
  a_ign: assert property (p_ign) else $error("missing pin went digital");
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_err: assert property (p_err) else $error("unmapped read not refused");
  a_rst: assert property (p_rst) else $error("reset values wrong");
  c_adv: cover property (dmaAdvance);
  c_ref: cover property (chZeroPosRef);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// ### adsc_top.v
// Function
// R1: event every increment-rate plus one conversions
// R2: alternate fill base 0x0/0x8 in mode one
// R3: fill status shows upper half active
// R4: words per input two to field power
// R5: channels 1-3 negative select decode
// R6: channels 1-3 positive select AN3-5/AN0-2
// R7: channel 0 negative zero uses reference
// R8: channel 0 positive field binary index
// R9: inputs 6-8 reserved on small package
// R10: scan mask bit includes input
// R11: missing scanned input converts reference
// R12: digital pin ties mux to ground
// R13: analog pin samples voltage
// R14: config bits ignored for missing inputs
// R15: unimplemented bits read zero
// R16: converter clock divider plus one
// R17: reset clears control fields
`timescale 1ns/1ps
`include "adsc_consts.vh"
module adsc_top #(
  parameter       NUM_INPUTS = 13,
  parameter       SMALL_PKG  = 0,
  parameter       FIFO_DEPTH = 16,
  parameter [12:0] PRESENT   = 13'h1fff
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // axi4-lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // converter result stream
  input  wire        convDone,
  input  wire [15:0] convData,
  output reg         convReady,
  // dma result stream
  output reg         dmaValid,
  input  wire        dmaReady,
  output reg  [15:0] dmaData,
  output reg  [3:0]  dmaBufAddr,
  output reg         dmaAdvance,
  output reg  [7:0]  dmaWordsPerInput,
  // analog front end
  output reg  [4:0]  chZeroPosIdx,
  output reg         chZeroPosRef,
  output reg         chZeroNegRef,
  output reg  [11:0] chOneThreeSel,
  output reg  [12:0] scanEnable,
  output reg  [12:0] scanUsesRef,
  output reg  [12:0] pinDigital,
  output reg  [12:0] muxToGround,
  output reg  [8:0]  convClkDiv,
  input  wire        sampleSetB
);
  reg  [15:0] seqCtl_q;
  reg  [15:0] clkCtl_q;
  reg  [15:0] dmaLen_q;
  reg  [15:0] chOneThree_q;
  reg  [15:0] chZero_q;
  reg  [15:0] scanMask_q;
  reg  [15:0] pinCfg_q;
  reg  [3:0]  convCnt_q;
  reg  [2:0]  slot_q;
  reg         fillHalf_q;
  reg         awHeld_q;
  reg         wHeld_q;
  reg  [7:0]  awAddr_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;
  wire [3:0]  rateCode;
  wire        fillMode;
  wire        fifoInReady;
  wire        fifoOutValid;
  wire [19:0] fifoOutData;
  wire        convTake;
  wire        lastOfGroup;
  wire [15:0] wVal;
  wire [3:0]  curAddr;
  wire [1:0]  negSel;
  wire        posSel;
  wire [4:0]  zeroPos;
  wire        zeroNeg;
  reg  [15:0] rdVal;
  reg         rdHit;
  reg  [15:0] oldVal;
  assign rateCode    = seqCtl_q[`ADSC_CONVERSIONS_PER_INTERRUPT_LSB+3:`ADSC_CONVERSIONS_PER_INTERRUPT_LSB];
  assign fillMode    = seqCtl_q[`ADSC_BUFFER_FILL_MODE_BIT];
  assign convTake    = convDone & fifoInReady;
  // R1: group end count
  assign lastOfGroup = (convCnt_q == rateCode);
  // byte strobes keep unwritten bytes
  assign wVal        = {(wStrb_q[1] ? wData_q[15:8] : oldVal[15:8]),
                        (wStrb_q[0] ? wData_q[7:0] : oldVal[7:0])};
  // R2: base of active half
  assign curAddr     = (fillHalf_q ? `ADSC_HALF_BASE : 4'h0) | {1'b0, slot_q};
  assign negSel  = sampleSetB ? chOneThree_q[10:9] : chOneThree_q[2:1];
  assign posSel  = sampleSetB ? chOneThree_q[8] : chOneThree_q[0];
  assign zeroPos = sampleSetB ? chZero_q[12:8] : chZero_q[4:0];
  assign zeroNeg = sampleSetB ? chZero_q[15] : chZero_q[7];

  adsc_fifo #(
    .WIDTH (20),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .inValid  (convDone),
    .inReady  (fifoInReady),
    .inData   ({curAddr, convData}),
    .outValid (fifoOutValid),
    .outReady (dmaReady | ~dmaValid),
    .outData  (fifoOutData)
  );

  // current value for byte merge
  always @* begin
    oldVal = 16'h0000;
    case (awAddr_q)
      `ADSC_OFS_SEQ: begin
        oldVal = seqCtl_q;
      end
      `ADSC_OFS_CLK: begin
        oldVal = clkCtl_q;
      end
      `ADSC_OFS_DMA: begin
        oldVal = dmaLen_q;
      end
      `ADSC_OFS_CH123: begin
        oldVal = chOneThree_q;
      end
      `ADSC_OFS_CH0: begin
        oldVal = chZero_q;
      end
      `ADSC_OFS_SCAN: begin
        oldVal = scanMask_q;
      end
      `ADSC_OFS_PIN_DIGITAL_SELECT: begin
        oldVal = pinCfg_q;
      end
      default: begin
        oldVal = 16'h0000;
      end
    endcase
  end

  // register file and bus slave
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      // R17: clear on reset
      seqCtl_q      <= `ADSC_RESET;
      clkCtl_q      <= `ADSC_RESET;
      dmaLen_q      <= `ADSC_RESET;
      chOneThree_q  <= `ADSC_RESET;
      chZero_q      <= `ADSC_RESET;
      scanMask_q    <= `ADSC_RESET;
      pinCfg_q      <= `ADSC_RESET;
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= ~awHeld_q & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld_q & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        case (awAddr_q)
          `ADSC_OFS_SEQ: begin
            seqCtl_q <= wVal & `ADSC_SEQ_MASK;
          end
          `ADSC_OFS_CLK: begin
            clkCtl_q <= wVal & `ADSC_CLK_MASK;
          end
          `ADSC_OFS_DMA: begin
            dmaLen_q <= wVal & `ADSC_DMA_MASK;
          end
          `ADSC_OFS_CH123: begin
            chOneThree_q <= wVal & `ADSC_CH123_MASK;
          end
          `ADSC_OFS_CH0: begin
            chZero_q <= wVal & `ADSC_CH0_MASK;
          end
          // R11: all scan bits writable
          `ADSC_OFS_SCAN: begin
            scanMask_q <= wVal & `ADSC_IN_MASK;
          end
          // R14: all config bits writable
          `ADSC_OFS_PIN_DIGITAL_SELECT: begin
            pinCfg_q <= wVal & `ADSC_IN_MASK;
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  always @* begin
    rdVal = 16'h0000;
    rdHit = 1'b1;
    // R15: unused bits zero
    case (s_axi_araddr)
      `ADSC_OFS_SEQ: begin
        rdVal = seqCtl_q | {8'h00, fillHalf_q, 7'h00};
      end
      `ADSC_OFS_CLK: begin
        rdVal = clkCtl_q;
      end
      `ADSC_OFS_DMA: begin
        rdVal = dmaLen_q;
      end
      `ADSC_OFS_CH123: begin
        rdVal = chOneThree_q;
      end
      `ADSC_OFS_CH0: begin
        rdVal = chZero_q;
      end
      `ADSC_OFS_SCAN: begin
        rdVal = scanMask_q;
      end
      `ADSC_OFS_PIN_DIGITAL_SELECT: begin
        rdVal = pinCfg_q;
      end
      `ADSC_OFS_RES: begin
        rdVal = {12'h000, convCnt_q};
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rdVal};
        s_axi_rresp  <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // conversion sequencing and dma stream
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      convCnt_q  <= 4'h0;
      slot_q     <= 3'h0;
      fillHalf_q <= 1'b0;
      dmaAdvance <= 1'b0;
      dmaValid   <= 1'b0;
      dmaData    <= 16'h0000;
      dmaBufAddr <= 4'h0;
      convReady  <= 1'b0;
    end else begin
      convReady  <= fifoInReady;
      dmaAdvance <= 1'b0;
      if (convTake) begin
        if (lastOfGroup) begin
          // R1: event after group
          convCnt_q  <= 4'h0;
          slot_q     <= 3'h0;
          dmaAdvance <= 1'b1;
          // R2: alternate halves
          // R3: status tracks half
          fillHalf_q <= fillMode ? ~fillHalf_q : 1'b0;
        end else begin
          convCnt_q <= convCnt_q + 4'h1;
          slot_q    <= slot_q + 3'h1;
        end
      end
      if (fifoOutValid && (dmaReady || !dmaValid)) begin
        dmaValid   <= 1'b1;
        dmaData    <= fifoOutData[15:0];
        // R2: location taken with word
        dmaBufAddr <= fifoOutData[19:16];
      end else if (dmaReady) begin
        dmaValid <= 1'b0;
      end
    end
  end

  // analog configuration outputs
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_pin
      always @(posedge ref_clk) begin
        if (!reset_n) begin
          scanEnable[gi]  <= 1'b0;
          scanUsesRef[gi] <= 1'b0;
          pinDigital[gi]  <= 1'b0;
          muxToGround[gi] <= 1'b0;
        end else begin
          // R10: scan include
          scanEnable[gi]  <= scanMask_q[gi];
          // R11: missing input to reference
          scanUsesRef[gi] <= scanMask_q[gi] & ~PRESENT[gi];
          // R12: digital grounds mux
          // R13: analog samples pin
          // R14: ignore missing ports
          pinDigital[gi]  <= pinCfg_q[gi] & PRESENT[gi];
          muxToGround[gi] <= pinCfg_q[gi] & PRESENT[gi];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      chZeroPosIdx     <= 5'h00;
      chZeroPosRef     <= 1'b0;
      chZeroNegRef     <= 1'b1;
      chOneThreeSel    <= 12'h000;
      convClkDiv       <= 9'h001;
      dmaWordsPerInput <= 8'h01;
    end else begin
      // R8: binary index
      chZeroPosIdx <= zeroPos;
      // R9: reserved codes use reference
      chZeroPosRef <= (SMALL_PKG != 0) && (zeroPos >= 5'h06) && (zeroPos <= 5'h08);
      // R7: zero selects reference
      chZeroNegRef <= ~zeroNeg;
      // R5: negative group decode
      case (negSel)
        2'b11: chOneThreeSel[11:6] <= {2'b11, 4'h9};
        2'b10: chOneThreeSel[11:6] <= {2'b10, 4'h6};
        default: chOneThreeSel[11:6] <= {2'b00, 4'h0};
      endcase
      // R6: positive group select
      chOneThreeSel[5:0] <= posSel ? {2'b01, 4'h3} : {2'b00, 4'h0};
      // R16: divider plus one
      convClkDiv <= {1'b0, clkCtl_q[7:0]} + 9'h001;
      // R4: two to the field
      dmaWordsPerInput <= 8'h01 << dmaLen_q[2:0];
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "adsc_consts.vh"
module testbench;
  localparam [12:0] PRES = 13'h1e3f;
  reg ref_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg s_axi_rready, convDone, sampleSetB, stall, bm;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd, v;
  reg [3:0] s_axi_wstrb, sm;
  reg [15:0] convData, rnd, sentCount, sentSum;
  reg [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, convReady;
  wire dmaValid, dmaReady, dmaAdvance, chZeroPosRef, chZeroNegRef;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] dmaData, rxCount, rxSum;
  wire [3:0] dmaBufAddr, lastAddr;
  wire [7:0] dmaWordsPerInput;
  wire [4:0] chZeroPosIdx;
  wire [11:0] chOneThreeSel;
  wire [12:0] scanEnable, scanUsesRef, pinDigital, muxToGround;
  wire [8:0] convClkDiv;
  integer fail_count, total_checks, advCount, i, k, s, n, e;
  adsc_top #(.SMALL_PKG(1), .PRESENT(PRES)) adsc_top_i (.*);
  adsc_dma_sink adsc_dma_sink_i (.*);
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (reset_n && dmaAdvance === 1'b1) advCount = advCount + 1;
  function [15:0] nxt(input [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function [31:0] msk(input integer j);
    case (j)
      0: msk = `ADSC_SEQ_MASK;
      1: msk = `ADSC_CLK_MASK;
      2: msk = `ADSC_DMA_MASK;
      3: msk = `ADSC_CH123_MASK;
      4: msk = `ADSC_CH0_MASK;
      default: msk = `ADSC_IN_MASK;
    endcase
  endfunction
  function [9:0] c123(input [2:0] c);
    c123 = {c[2] ? c[2:1] : 2'b00, c[2:1] == 2'b11 ? 4'h9 : c[2] ? 4'h6 : 4'h0,
            c[0] ? 4'h3 : 4'h0};
  endfunction
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tmo(input integer c);
    if (c >= 200) begin
      fail_count = fail_count + 1;
      $display("[ERR] wait expected done seen timeout");
      finish_test;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer c;
    begin
      c = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge ref_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        c = c + 1;
      end while (s_axi_bvalid !== 1'b1 && c < 200);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tmo(c);
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task rdr(input [7:0] a);
    integer c;
    begin
      c = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge ref_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        c = c + 1;
      end while (s_axi_rvalid !== 1'b1 && c < 200);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      tmo(c);
      @(posedge ref_clk);
    end
  endtask
  task send(input [15:0] d);
    integer c;
    begin
      c = 0;
      while (convReady !== 1'b1 && c < 200) begin
        @(posedge ref_clk);
        c = c + 1;
      end
      tmo(c);
      convData <= d;
      convDone <= 1'b1;
      @(posedge ref_clk);
      convDone <= 1'b0;
      repeat (2) @(posedge ref_clk);
      sentCount = sentCount + 16'h1;
      sentSum = sentSum + d;
    end
  endtask
  task drain;
    integer c;
    begin
      c = 0;
      while (rxCount !== sentCount && c < 200) begin
        @(posedge ref_clk);
        c = c + 1;
      end
      tmo(c);
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task rst;
    begin
      reset_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      sentCount = 16'h0;
      sentSum = 16'h0;
      advCount = 0;
      @(posedge ref_clk);
    end
  endtask
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, convDone, sampleSetB, stall, s_axi_awaddr, s_axi_araddr} = 20'h0;
    {s_axi_wdata, convData} = 48'h0;
    s_axi_wstrb = 4'hf;
    rnd = 16'h2f68;
    fail_count = 0;
    total_checks = 0;
    rst;
    for (i = 0; i < 8; i = i + 1) begin
      rdr(i * 4);
      chk("reset value", rd, 0);
    end
    wr(8'h20, 32'h1);
    chk("bresp", rsp, 2);
    rdr(8'h24);
    chk("rresp", rsp, 2);
    $display("test reset and map done");
    for (k = 0; k < 4; k = k + 1) for (i = 0; i < 7; i = i + 1) begin
      rnd = nxt(rnd);
      v = {rnd, nxt(rnd)};
      wr(i * 4, v);
      rdr(i * 4);
      chk("readback", rd, v & msk(i));
      if (i == 1) chk("divider", convClkDiv, v[7:0] + 1);
      if (i == 5) chk("scan", scanEnable, v[12:0]);
      if (i == 5) chk("scan ref", scanUsesRef, v[12:0] & ~PRES);
      if (i == 6) chk("digital", pinDigital, v[12:0] & PRES);
      if (i == 6) chk("ground", muxToGround, v[12:0] & PRES);
    end
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h08, i);
      chk("words", dmaWordsPerInput, 1 << i);
    end
    $display("test registers done");
    for (i = 0; i < 13; i = i + 1) begin
      wr(8'h0c, {21'h0, ~i[2:0], 5'h0, i[2:0]});
      for (s = 0; s < 2; s = s + 1) begin
        sampleSetB <= s;
        repeat (3) @(posedge ref_clk);
        chk("ch123", {chOneThreeSel[11:6], chOneThreeSel[3:0]}, c123(s ? ~i : i));
      end
      wr(8'h10, {16'h0, 3'b100, 5'd12 - i[4:0], 3'b000, i[4:0]});
      for (s = 0; s < 2; s = s + 1) begin
        e = s ? 12 - i : i;
        sampleSetB <= s;
        repeat (3) @(posedge ref_clk);
        chk("ch0 pos", chZeroPosIdx, e);
        chk("ch0 neg", chZeroNegRef, !s);
        chk("ch0 resv", chZeroPosRef, e >= 6 && e <= 8);
      end
    end
    $display("test channel select done");
    rst;
    for (i = 0; i < 3; i = i + 1) begin
      sm = i == 0 ? 4'h0 : i == 1 ? 4'h3 : 4'hf;
      bm = i != 0;
      wr(8'h00, {26'h0, sm, bm, 1'b0});
      advCount = 0;
      for (k = 1; k < 3; k = k + 1) begin
        repeat (sm + 1) begin
          rnd = nxt(rnd);
          send(rnd);
        end
        drain;
        chk("advance", advCount, k);
        rdr(8'h00);
        chk("fill status", rd[7], bm & k[0]);
        if (sm != 4'hf) chk("buf addr", lastAddr, (bm && k == 2 ? 8 : 0) + sm);
      end
    end
    $display("test stream done");
    wr(8'h00, 32'h0);
    stall <= 1'b1;
    n = 0;
    while (convReady === 1'b1 && n < 20) begin
      rnd = nxt(rnd);
      send(rnd);
      n = n + 1;
    end
    chk("depth", n, 17);
    stall <= 1'b0;
    drain;
    chk("sum", rxSum, sentSum);
    $display("test fill done");
    finish_test;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count = fail_count + 1;
    $display("[ERR] run expected end seen hang");
    finish_test;
  end
endmodule
bind adsc_top adsc_props #(.SMALL_PKG(SMALL_PKG), .PRESENT(PRESENT)) adsc_props_i (.*);
